// >>> common/psdc_pkg.sv
package psdc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [31:0] ADDR_SYS_CONFIG = 32'h005F_6C80;
	localparam logic [31:0] ADDR_STATUS     = 32'h005F_6C84;
	localparam logic [31:0] ADDR_TRIG_CLEAR = 32'h005F_6C88;
	localparam logic [31:0] ADDR_WINDOW     = 32'h005F_6C8C;
	localparam logic [31:0] ADDR_BIT_ORDER  = 32'h005F_6CE8;
	localparam logic [31:0] ADDR_TX_COUNT   = 32'h005F_6CF4;
	localparam logic [31:0] ADDR_RX_COUNT   = 32'h005F_6CF8;
	localparam logic [31:0] ADDR_RX_BASE    = 32'h005F_6CFC;

	////////////////////////////////////////////////////////////////////////////////
	// Field layouts and reset values
	localparam int          CFG_TMO_LSB  = 16;
	localparam int          CFG_SHT_BIT  = 12;
	localparam int          CFG_RATE_LSB = 8;
	localparam int          CFG_DLY_LSB  = 0;
	localparam logic [31:0] CFG_MASK     = 32'hFFFF_130F;
	localparam logic [31:0] CFG_RST      = 32'h3A98_0000;
	localparam int          ST_BUSY_BIT  = 31;
	localparam int          WIN_KEY_LSB  = 16;
	localparam logic [15:0] WIN_KEY      = 16'h6155;
	localparam int          WIN_TOP_LSB  = 8;
	localparam int          WIN_BOT_LSB  = 0;
	localparam logic [6:0]  WIN_TOP_RST  = 7'h7F;
	localparam logic [6:0]  WIN_BOT_RST  = 7'h00;
	localparam logic [1:0]  WIN_HIGH     = 2'h1;
	localparam int          ACNT_LSB     = 5;
	localparam logic [7:0]  LINE_IDLE    = 8'hFF;
	localparam logic        BITORD_RST   = 1'b1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS  = 5;
	localparam int TMO_STEP_NS    = 20;
	localparam int TMO_STEP_CYC   = (TMO_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_STEP_US    = 1300;
	localparam int DLY_STEP_CYC   = (DLY_STEP_US * 1000) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Bus carriers
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} psdc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} psdc_axil_rsp_t;

endpackage

// >>> rtl/psdc_sync.sv
`timescale 1ns/1ps
module psdc_sync #(
	parameter int           W   = 8,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// Stages 1..3 plus the accepted value; stage 1 feeds only stage 2
	logic [3:0][W-1:0] s_q;
	logic [3:0][W-1:0] s_d;

	always_comb begin
		s_d[0] = async_in;
		s_d[1] = s_q[0];
		s_d[2] = s_q[1];
		s_d[3] = s_q[3];
		for (int i = 0; i < W; i++) begin
			if (s_q[1][i] == s_q[2][i]) begin
				s_d[3][i] = s_q[2][i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= {4{RST}};
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q[3];
endmodule

// >>> rtl/psdc_delay.sv
`timescale 1ns/1ps
module psdc_delay #(
	parameter int STEP_CYC = 260000
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       load,
	input  wire logic [3:0] steps,
	input  wire logic       abort,
	output logic            done
);
	typedef struct packed {
		logic        run;
		logic [3:0]  steps;
		logic [31:0] cyc;
		logic        done;
	} psdc_dly_state_t;

	psdc_dly_state_t s_q;
	psdc_dly_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (abort) begin
			s_d.run = 1'b0;
		end else if (load) begin
			s_d.run   = 1'b1;
			s_d.steps = steps;
			s_d.cyc   = 32'h0000_0000;
		end else if (s_q.run) begin
			if (s_q.steps == 4'h0) begin
				s_d.run  = 1'b0;
				s_d.done = 1'b1;
			end else if (s_q.cyc == 32'(STEP_CYC - 1)) begin
				s_d.cyc   = 32'h0000_0000;
				s_d.steps = s_q.steps - 4'h1;
			end else begin
				s_d.cyc = s_q.cyc + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;
endmodule

// >>> rtl/psdc_ctrl.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Config bits 31-16 set response timeout in 20 ns steps, reset 0x3A98.
// - Config bit 12 zero restarts every vblank; one waits for trigger clear.
// - Config bits 9-8 pick line rate: 00 is 2 Mbps default, 01 1 Mbps.
// - Config bits 3-0 delay vblank start in 1.3 ms steps, default zero.
// - Single trigger and delay apply only with vblank trigger source.
// - Hardware never changes the config register; it holds the last write.
// - Status bit 31 shows busy; software must not overwrite transmit data then.
// - Status bits 26-24 show frame counter, 21-16 state counter, zero at reset.
// - Status bits 7-0 show live port lines, A on odd bits, B on even bits, idle 0xFF.
// - Writing one to trigger clear bit 0 re-arms vblank; zero is ignored.
// - Trigger clear counts only with vblank source and manual single trigger.
// - Window fields change only when bits 31-16 of the write carry 0x6155.
// - Window start from bits 14-8 as A26-A20, A28-A27 01, reset 0x7F.
// - Window end from bits 6-0, same encoding, reset 0x00.
// - Memory accesses outside the window are refused and flag overrun.
// - Bit-order bit 0 picks MSB position: 0 bit 7, 1 bit 31 default.
// - Read-only transmit address counter in bits 28-5, never reset.
// - Read-only receive address counter and base in bits 28-5, never reset.
// - Trigger select 0 starts from software; 1 starts at vblank end.
module psdc_ctrl #(
	parameter int DLY_STEP_CYC = psdc_pkg::DLY_STEP_CYC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire psdc_pkg::psdc_axil_req_t axil_req,
	output psdc_pkg::psdc_axil_rsp_t      axil_rsp,
	input  wire logic                     dma_trigger_select,
	input  wire logic                     sw_start,
	input  wire logic                     vblank_out,
	output logic                          dma_start,
	input  wire logic                     xfer_busy,
	input  wire logic [2:0]               frame_count,
	input  wire logic [5:0]               state_count,
	input  wire logic [3:0]               port_line_a,
	input  wire logic [3:0]               port_line_b,
	output logic [1:0]                    line_rate_sel,
	output logic                          msb_bit31,
	input  wire logic                     resp_wait_start,
	input  wire logic                     resp_wait_stop,
	output logic                          resp_timeout,
	input  wire logic                     mem_req_valid,
	input  wire logic [28:0]              mem_req_addr,
	output logic                          mem_req_allow,
	output logic                          overrun_error,
	input  wire logic                     tx_addr_set,
	input  wire logic [23:0]              tx_addr_next,
	input  wire logic                     rx_addr_set,
	input  wire logic [23:0]              rx_addr_next,
	input  wire logic                     rx_base_set,
	input  wire logic [23:0]              rx_base_next
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [31:0] cfg;
		logic        bitord;
		logic [6:0]  win_top;
		logic [6:0]  win_bot;
		logic        armed;
		logic        aw_have;
		logic [31:0] aw_addr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        start;
		logic        tmo_run;
		logic [17:0] tmo_cnt;
		logic        tmo;
		logic        overrun;
	} psdc_state_t;

	psdc_state_t s_q;
	psdc_state_t s_d;

	logic [23:0] tx_cnt_q;
	logic [23:0] rx_cnt_q;
	logic [23:0] rx_base_q;
	logic [7:0]  line_sync;
	logic [7:0]  line_raw;
	logic        sht_manual;
	logic        vb_fire;
	logic        dly_done;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic [31:0] strb_mask;
	logic [31:0] rd_mux;
	logic        rd_hit;
	logic        wr_hit;
	logic [17:0] tmo_limit;
	logic        clear_req;

	////////////////////////////////////////////////////////////////////////////////
	// Line monitor: pins pass four flops before they are shown
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			line_raw[2*p+1] = port_line_a[p];
			line_raw[2*p]   = port_line_b[p];
		end
	end

	psdc_sync #(
		.W   (8),
		.RST (psdc_pkg::LINE_IDLE)
	) u_line_sync (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.async_in (line_raw),
		.sync_out (line_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Vblank start delay
	assign sht_manual = s_q.cfg[psdc_pkg::CFG_SHT_BIT];
	assign vb_fire    = vblank_out && dma_trigger_select && (s_q.armed || !sht_manual);

	psdc_delay #(
		.STEP_CYC (DLY_STEP_CYC)
	) u_delay (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.load    (vb_fire),
		.steps   (s_q.cfg[psdc_pkg::CFG_DLY_LSB +: 4]),
		.abort   (!dma_trigger_select),
		.done    (dly_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes and decode
	assign aw_hs = axil_req.awvalid && !s_q.aw_have && !s_q.bvalid;
	assign w_hs  = axil_req.wvalid && !s_q.w_have && !s_q.bvalid;
	assign ar_hs = axil_req.arvalid && !s_q.rvalid;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			strb_mask[8*b +: 8] = {8{s_q.wstrb[b]}};
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (axil_req.araddr[31:2])
			psdc_pkg::ADDR_SYS_CONFIG[31:2]: rd_mux = s_q.cfg;
			psdc_pkg::ADDR_STATUS[31:2]: begin
				rd_mux[psdc_pkg::ST_BUSY_BIT] = xfer_busy;
				rd_mux[26:24]                 = frame_count;
				rd_mux[21:16]                 = state_count;
				rd_mux[7:0]                   = line_sync;
			end
			psdc_pkg::ADDR_TRIG_CLEAR[31:2]: rd_mux = 32'h0000_0000;
			psdc_pkg::ADDR_WINDOW[31:2]:     rd_mux = 32'h0000_0000;
			psdc_pkg::ADDR_BIT_ORDER[31:2]:  rd_mux[0] = s_q.bitord;
			psdc_pkg::ADDR_TX_COUNT[31:2]:   rd_mux[psdc_pkg::ACNT_LSB +: 24] = tx_cnt_q;
			psdc_pkg::ADDR_RX_COUNT[31:2]:   rd_mux[psdc_pkg::ACNT_LSB +: 24] = rx_cnt_q;
			psdc_pkg::ADDR_RX_BASE[31:2]:    rd_mux[psdc_pkg::ACNT_LSB +: 24] = rx_base_q;
			default:                         rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		case (s_q.aw_addr[31:2])
			psdc_pkg::ADDR_SYS_CONFIG[31:2],
			psdc_pkg::ADDR_STATUS[31:2],
			psdc_pkg::ADDR_TRIG_CLEAR[31:2],
			psdc_pkg::ADDR_WINDOW[31:2],
			psdc_pkg::ADDR_BIT_ORDER[31:2],
			psdc_pkg::ADDR_TX_COUNT[31:2],
			psdc_pkg::ADDR_RX_COUNT[31:2],
			psdc_pkg::ADDR_RX_BASE[31:2]: wr_hit = 1'b1;
			default:                      wr_hit = 1'b0;
		endcase
	end

	assign clear_req = s_q.aw_have && s_q.w_have
		&& (s_q.aw_addr[31:2] == psdc_pkg::ADDR_TRIG_CLEAR[31:2])
		&& s_q.wstrb[0] && s_q.wdata[0]
		&& dma_trigger_select && sht_manual;

	assign tmo_limit = 18'(s_q.cfg[psdc_pkg::CFG_TMO_LSB +: 16] * psdc_pkg::TMO_STEP_CYC);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d         = s_q;
		s_d.start   = 1'b0;
		s_d.tmo     = 1'b0;
		s_d.overrun = 1'b0;

		if (aw_hs) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axil_req.awaddr;
		end
		if (w_hs) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = axil_req.wdata;
			s_d.wstrb  = axil_req.wstrb;
		end
		if (s_q.bvalid && axil_req.bready) begin
			s_d.bvalid = 1'b0;
		end

		// Write commits one cycle after both halves are held
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_hit ? psdc_pkg::RESP_OKAY : psdc_pkg::RESP_SLVERR;
			case (s_q.aw_addr[31:2])
				psdc_pkg::ADDR_SYS_CONFIG[31:2]: begin
					s_d.cfg = ((s_q.cfg & ~strb_mask) | (s_q.wdata & strb_mask))
						& psdc_pkg::CFG_MASK;
				end
				psdc_pkg::ADDR_WINDOW[31:2]: begin
					// Partial strobes cannot carry key and fields together
					if ((s_q.wstrb == 4'hF)
						&& (s_q.wdata[psdc_pkg::WIN_KEY_LSB +: 16] == psdc_pkg::WIN_KEY)) begin
						s_d.win_top = s_q.wdata[psdc_pkg::WIN_TOP_LSB +: 7];
						s_d.win_bot = s_q.wdata[psdc_pkg::WIN_BOT_LSB +: 7];
					end
				end
				psdc_pkg::ADDR_BIT_ORDER[31:2]: begin
					if (s_q.wstrb[0]) begin
						s_d.bitord = s_q.wdata[0];
					end
				end
				default: begin
				end
			endcase
		end

		if (ar_hs) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_mux;
			s_d.rresp  = rd_hit ? psdc_pkg::RESP_OKAY : psdc_pkg::RESP_SLVERR;
		end else if (s_q.rvalid && axil_req.rready) begin
			s_d.rvalid = 1'b0;
		end

		// DMA start: software path, or vblank path after the delay
		if (!dma_trigger_select && sw_start) begin
			s_d.start = 1'b1;
		end else if (dma_trigger_select && dly_done) begin
			s_d.start = 1'b1;
		end
		// Single trigger disarms on the vblank that launches; re-arm wins a tie
		if (vb_fire && sht_manual) begin
			s_d.armed = 1'b0;
		end
		if (clear_req) begin
			s_d.armed = 1'b1;
		end

		// Response timeout from start of output
		if (resp_wait_start) begin
			s_d.tmo_run = 1'b1;
			s_d.tmo_cnt = 18'h00000;
		end else if (resp_wait_stop) begin
			s_d.tmo_run = 1'b0;
		end else if (s_q.tmo_run) begin
			if (s_q.tmo_cnt >= tmo_limit) begin
				s_d.tmo_run = 1'b0;
				s_d.tmo     = 1'b1;
			end else begin
				s_d.tmo_cnt = s_q.tmo_cnt + 18'h00001;
			end
		end

		if (mem_req_valid && !mem_req_allow) begin
			s_d.overrun = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q         <= '0;
			s_q.cfg     <= psdc_pkg::CFG_RST;
			s_q.bitord  <= psdc_pkg::BITORD_RST;
			s_q.win_top <= psdc_pkg::WIN_TOP_RST;
			s_q.win_bot <= psdc_pkg::WIN_BOT_RST;
			s_q.armed   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Debug address counters keep their value through reset by design
	always_ff @(posedge sys_clk) begin
		if (tx_addr_set) begin
			tx_cnt_q <= tx_addr_next;
		end
		if (rx_addr_set) begin
			rx_cnt_q <= rx_addr_next;
		end
		if (rx_base_set) begin
			rx_base_q <= rx_base_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	// A reversed window admits nothing, which is safer than wrapping
	assign mem_req_allow = (mem_req_addr[28:27] == psdc_pkg::WIN_HIGH)
		&& (mem_req_addr[26:20] >= s_q.win_top)
		&& (mem_req_addr[26:20] <= s_q.win_bot);

	assign axil_rsp.awready = !s_q.aw_have && !s_q.bvalid;
	assign axil_rsp.wready  = !s_q.w_have && !s_q.bvalid;
	assign axil_rsp.bvalid  = s_q.bvalid;
	assign axil_rsp.bresp   = s_q.bresp;
	assign axil_rsp.arready = !s_q.rvalid;
	assign axil_rsp.rvalid  = s_q.rvalid;
	assign axil_rsp.rdata   = s_q.rdata;
	assign axil_rsp.rresp   = s_q.rresp;

	assign dma_start     = s_q.start;
	assign line_rate_sel = s_q.cfg[psdc_pkg::CFG_RATE_LSB +: 2];
	assign msb_bit31     = s_q.bitord;
	assign resp_timeout  = s_q.tmo;
	assign overrun_error = s_q.overrun;
endmodule

// >>> dv/psdc_lines_model.sv
`timescale 1ns/1ps
module psdc_lines_model (
	input  wire logic       drive,
	input  wire logic [7:0] pat,
	output logic      [3:0] port_line_a,
	output logic      [3:0] port_line_b
);
	// Released lines float high on their pull-ups
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_line_a[i] = drive ? pat[2*i+1] : 1'b1;
			port_line_b[i] = drive ? pat[2*i] : 1'b1;
		end
	end
endmodule

// >>> dv/psdc_ctrl_monitor.sv
`timescale 1ns/1ps
module psdc_ctrl_monitor (
	input wire logic                     sys_clk,
	input wire logic                     arst_n,
	input wire psdc_pkg::psdc_axil_req_t axil_req,
	input wire psdc_pkg::psdc_axil_rsp_t axil_rsp,
	input wire logic                     dma_trigger_select,
	input wire logic                     sw_start,
	input wire logic                     dma_start,
	input wire logic                     xfer_busy,
	input wire logic [2:0]               frame_count,
	input wire logic [5:0]               state_count,
	input wire logic [1:0]               line_rate_sel,
	input wire logic                     msb_bit31,
	input wire logic                     mem_req_valid,
	input wire logic [28:0]              mem_req_addr,
	input wire logic                     mem_req_allow,
	input wire logic                     overrun_error
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// Read data lands one edge after the address handshake
	logic ar_hit, st_rd, wo_rd;
	assign ar_hit = axil_req.arvalid && axil_rsp.arready;
	assign st_rd  = ar_hit && axil_req.araddr == psdc_pkg::ADDR_STATUS;
	assign wo_rd  = ar_hit && (axil_req.araddr == psdc_pkg::ADDR_WINDOW
		|| axil_req.araddr == psdc_pkg::ADDR_TRIG_CLEAR);
	chk_busy_bit: assert property (
		st_rd |=> axil_rsp.rdata[31] == $past(xfer_busy))
		else $error("status busy bit wrong");
	chk_count_fields: assert property (st_rd |=>
		axil_rsp.rdata[26:24] == $past(frame_count) && axil_rsp.rdata[21:16] == $past(state_count))
		else $error("status counter fields wrong");
	chk_wo_zero: assert property (wo_rd |=> axil_rsp.rdata == 32'h0000_0000)
		else $error("write-only register read nonzero");
	chk_overrun_set: assert property (
		mem_req_valid && !mem_req_allow |=> overrun_error)
		else $error("overrun missing");
	chk_overrun_clr: assert property (
		!(mem_req_valid && !mem_req_allow) |=> !overrun_error)
		else $error("spurious overrun");
	chk_window_high: assert property (
		mem_req_allow |-> mem_req_addr[28:27] == psdc_pkg::WIN_HIGH)
		else $error("allowed outside high bits");
	chk_sw_launch: assert property (
		!dma_trigger_select && sw_start |=> dma_start)
		else $error("software start lost");
	// Only a bus write may move mirrored config fields
	chk_rate_hold: assert property (
		$changed(line_rate_sel) |-> axil_rsp.bvalid || $past(axil_rsp.bvalid))
		else $error("rate changed without write");
	chk_msb_hold: assert property (
		$changed(msb_bit31) |-> axil_rsp.bvalid || $past(axil_rsp.bvalid))
		else $error("bit order changed without write");
	cover property (dma_start);
	cover property (overrun_error);
	cover property (st_rd ##1 axil_rsp.rdata[31]);
endmodule

bind psdc_ctrl psdc_ctrl_monitor psdc_ctrl_monitor_inst (
	.sys_clk, .arst_n, .axil_req, .axil_rsp, .dma_trigger_select, .sw_start,
	.dma_start, .xfer_busy, .frame_count, .state_count, .line_rate_sel, .msb_bit31,
	.mem_req_valid, .mem_req_addr, .mem_req_allow, .overrun_error
);

// >>> dv/peripheral_serial_dma_control_tb.sv
`timescale 1ns/1ps
module peripheral_serial_dma_control_tb;
	psdc_pkg::psdc_axil_req_t axil_req;
	psdc_pkg::psdc_axil_rsp_t axil_rsp;
	logic        sys_clk, arst_n, dma_trigger_select, sw_start, vblank_out, dma_start;
	logic        xfer_busy, msb_bit31, resp_wait_start, resp_wait_stop, resp_timeout;
	logic        mem_req_valid, mem_req_allow, overrun_error, drive;
	logic        tx_addr_set, rx_addr_set, rx_base_set;
	logic [2:0]  frame_count;
	logic [5:0]  state_count;
	logic [3:0]  port_line_a, port_line_b;
	logic [1:0]  line_rate_sel, r;
	logic [7:0]  pat;
	logic [28:0] mem_req_addr;
	logic [23:0] tx_addr_next, rx_addr_next, rx_base_next;
	logic [31:0] d;
	int          n_errors, checks;
	localparam int VB = 0;
	localparam int SW = 1;
	localparam int WS = 2;
	localparam int WP = 3;
	// Short delay step keeps vblank runs brief
	psdc_ctrl #(.DLY_STEP_CYC(10)) psdc_ctrl_inst (
		.sys_clk, .arst_n, .axil_req, .axil_rsp, .dma_trigger_select, .sw_start,
		.vblank_out, .dma_start, .xfer_busy, .frame_count, .state_count, .port_line_a,
		.port_line_b, .line_rate_sel, .msb_bit31, .resp_wait_start, .resp_wait_stop,
		.resp_timeout, .mem_req_valid, .mem_req_addr, .mem_req_allow, .overrun_error,
		.tx_addr_set, .tx_addr_next, .rx_addr_set, .rx_addr_next, .rx_base_set, .rx_base_next
	);
	psdc_lines_model psdc_lines_model_inst (.drive, .pat, .port_line_a, .port_line_b);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////
	task summarize;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task hang;
		n_errors++;
		$display("Error wait expected answer seen timeout");
		summarize();
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task rst;
		arst_n <= 1'b0;
		cyc(16);
		arst_n <= 1'b1;
		cyc(4);
	endtask
	task wr(input logic [31:0] a, input logic [31:0] v);
		int i;
		@(posedge sys_clk);
		axil_req.awaddr  <= a;
		axil_req.wdata   <= v;
		axil_req.awvalid <= 1'b1;
		axil_req.wvalid  <= 1'b1;
		axil_req.bready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
			if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
			if (axil_rsp.bvalid === 1'b1) break;
		end
		r = axil_rsp.bresp;
		axil_req.bready <= 1'b0;
		if (i == 50) hang();
	endtask
	task rd(input logic [31:0] a);
		int i;
		@(posedge sys_clk);
		axil_req.araddr  <= a;
		axil_req.arvalid <= 1'b1;
		axil_req.rready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
			if (axil_rsp.rvalid === 1'b1) break;
		end
		d = axil_rsp.rdata;
		r = axil_rsp.rresp;
		axil_req.rready <= 1'b0;
		if (i == 50) hang();
	endtask
	task rc(input string nm, input logic [31:0] a, input logic [31:0] e);
		rd(a);
		ck(nm, e, d);
	endtask
	// Pulse one event input for a single cycle, then count edges to the answer
	task go(input string nm, input int k, input bit w, input int lo, input int hi);
		int n;
		@(posedge sys_clk);
		{resp_wait_stop, resp_wait_start, sw_start, vblank_out} <= 4'h1 << k;
		@(posedge sys_clk);
		{resp_wait_stop, resp_wait_start, sw_start, vblank_out} <= 4'h0;
		n = -1;
		for (int i = 0; i < 40 && n < 0; i++) begin
			@(posedge sys_clk);
			if ((w ? resp_timeout : dma_start) === 1'b1) n = i;
		end
		checks++;
		if (n < lo || n > hi) begin
			n_errors++;
			$display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, n);
		end
	endtask
	task mck(input logic [28:0] a, input logic e);
		@(posedge sys_clk);
		mem_req_valid <= 1'b1;
		mem_req_addr  <= a;
		@(posedge sys_clk);
		ck("allow", e, mem_req_allow);
		mem_req_valid <= 1'b0;
		@(posedge sys_clk);
		ck("overrun", !e, overrun_error);
	endtask
	////////////////////////////////////////
	task t_reset;
		rc("config", psdc_pkg::ADDR_SYS_CONFIG, psdc_pkg::CFG_RST);
		rc("status", psdc_pkg::ADDR_STATUS, 32'h0000_00FF);
		rc("bitord", psdc_pkg::ADDR_BIT_ORDER, 32'h0000_0001);
		ck("rate", 32'h0, line_rate_sel);
	endtask
	task t_cfg;
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'hFFFF_FFFF);
		rc("config", psdc_pkg::ADDR_SYS_CONFIG, psdc_pkg::CFG_MASK);
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_0100);
		cyc(1);
		ck("rate", 32'h1, line_rate_sel);
		wr(psdc_pkg::ADDR_BIT_ORDER, 32'h0);
		cyc(1);
		ck("msb", 32'h0, msb_bit31);
		wr(32'h005F_6C90, 32'h0);
		ck("bresp", psdc_pkg::RESP_SLVERR, r);
		rc("rdata", 32'h005F_6C90, 32'h0);
		ck("rresp", psdc_pkg::RESP_SLVERR, r);
		rc("config", psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_0100);
	endtask
	task t_stat;
		xfer_busy   <= 1'b1;
		frame_count <= 3'h5;
		state_count <= 6'h2A;
		pat         <= 8'h96;
		drive       <= 1'b1;
		cyc(5);
		rc("status", psdc_pkg::ADDR_STATUS, 32'h852A_0096);
		xfer_busy <= 1'b0;
		drive     <= 1'b0;
		cyc(5);
		rc("status", psdc_pkg::ADDR_STATUS, 32'h052A_00FF);
	endtask
	task t_win;
		mck({2'h1, 7'h7F, 20'h0}, 1'b0);
		wr(psdc_pkg::ADDR_WINDOW, 32'h6154_407F);
		mck({2'h1, 7'h40, 20'h0}, 1'b0);
		wr(psdc_pkg::ADDR_WINDOW, 32'h6155_407F);
		mck({2'h1, 7'h40, 20'h0}, 1'b1);
		// Keyed write with partial strobes must leave the window alone
		axil_req.wstrb <= 4'h3;
		wr(psdc_pkg::ADDR_WINDOW, 32'h6155_7F7F);
		axil_req.wstrb <= 4'hF;
		mck({2'h1, 7'h40, 20'h0}, 1'b1);
		mck({2'h1, 7'h7F, 20'hFFFFF}, 1'b1);
		mck({2'h1, 7'h3F, 20'hFFFFF}, 1'b0);
		mck({2'h2, 7'h40, 20'h0}, 1'b0);
		rc("window", psdc_pkg::ADDR_WINDOW, 32'h0);
		rc("tclear", psdc_pkg::ADDR_TRIG_CLEAR, 32'h0);
	endtask
	task t_vb;
		dma_trigger_select <= 1'b1;
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_0002);
		go("delay", VB, 0, 20, 26);
		go("auto", VB, 0, 20, 26);
		go("swsel1", SW, 0, -1, -1);
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_1000);
		go("manual", VB, 0, 1, 4);
		go("disarmed", VB, 0, -1, -1);
		wr(psdc_pkg::ADDR_TRIG_CLEAR, 32'h0);
		go("clear0", VB, 0, -1, -1);
		dma_trigger_select <= 1'b0;
		wr(psdc_pkg::ADDR_TRIG_CLEAR, 32'h1);
		dma_trigger_select <= 1'b1;
		go("clearsel0", VB, 0, -1, -1);
		wr(psdc_pkg::ADDR_TRIG_CLEAR, 32'h1);
		go("rearm", VB, 0, 1, 4);
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_0000);
		wr(psdc_pkg::ADDR_TRIG_CLEAR, 32'h1);
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_1000);
		go("clearauto", VB, 0, -1, -1);
		rc("config", psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_1000);
	endtask
	task t_sw;
		dma_trigger_select <= 1'b0;
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h3A98_1002);
		go("sw", SW, 0, 0, 0);
		go("sw2", SW, 0, 0, 0);
		go("vbsel0", VB, 0, -1, -1);
	endtask
	task t_tmo;
		wr(psdc_pkg::ADDR_SYS_CONFIG, 32'h0005_0000);
		go("timeout", WS, 1, 5 * psdc_pkg::TMO_STEP_CYC - 2, 5 * psdc_pkg::TMO_STEP_CYC + 6);
		go("started", WS, 1, 0, 39);
		// A running count is stopped well before its limit
		@(posedge sys_clk);
		resp_wait_start <= 1'b1;
		@(posedge sys_clk);
		resp_wait_start <= 1'b0;
		go("stopped", WP, 1, -1, -1);
	endtask
	// Counters are not cleared by reset, so a second pass follows a reset
	task t_cnt;
		@(posedge sys_clk);
		tx_addr_next <= 24'hA5C3E1;
		rx_addr_next <= 24'h5A3C1E;
		rx_base_next <= 24'h123456;
		{tx_addr_set, rx_addr_set, rx_base_set} <= 3'h7;
		@(posedge sys_clk);
		{tx_addr_set, rx_addr_set, rx_base_set} <= 3'h0;
		for (int i = 0; i < 2; i++) begin
			rc("txcnt", psdc_pkg::ADDR_TX_COUNT, {3'h0, 24'hA5C3E1, 5'h0});
			rc("rxcnt", psdc_pkg::ADDR_RX_COUNT, {3'h0, 24'h5A3C1E, 5'h0});
			rc("rxbase", psdc_pkg::ADDR_RX_BASE, {3'h0, 24'h123456, 5'h0});
			rst();
		end
	endtask
	////////////////////////////////////////
	initial begin
		axil_req = '0;
		axil_req.wstrb = 4'hF;
		{arst_n, dma_trigger_select, sw_start, vblank_out, xfer_busy, drive} = 6'h0;
		{resp_wait_start, resp_wait_stop, mem_req_valid} = 3'h0;
		{tx_addr_set, rx_addr_set, rx_base_set} = 3'h0;
		{frame_count, state_count, pat, mem_req_addr} = '0;
		{tx_addr_next, rx_addr_next, rx_base_next} = '0;
		n_errors = 0;
		checks = 0;
		rst();
		t_reset();
		t_cfg();
		t_stat();
		t_win();
		t_vb();
		t_sw();
		t_tmo();
		t_cnt();
		summarize();
	end
endmodule
